/* File: call_return_pkg.sv */
// Constants, opcode patterns and reset values for the call, return and software reset execution slice.
// Assumes a 16-bit instruction word, a 21-bit program counter and four phases per instruction cycle.
package call_return_pkg;
    localparam int          PC_W            = 21;
    localparam int          STATUS_W        = 5;
    localparam int          BANK_W          = 4;
    localparam int          LATU_W          = 5;
    localparam int          STACK_DEPTH     = 31;
    localparam int          OFFSET_W        = 11;
    localparam logic [1:0]  PHASE_Q1        = 2'h0;
    localparam logic [1:0]  PHASE_Q2        = 2'h1;
    localparam logic [1:0]  PHASE_Q3        = 2'h2;
    localparam logic [1:0]  PHASE_Q4        = 2'h3;
    localparam logic [4:0]  CALL_REL_TOP5   = 5'h1b;
    localparam logic [15:0] SOFT_RESET_WORD = 16'h00ff;
    localparam logic [14:0] IRQ_RET_TOP15   = 15'h0008;
    localparam logic [7:0]  LIT_RET_TOP8    = 8'h0c;
    localparam logic [15:0] NOP_WORD        = 16'h0000;
    localparam logic [20:0] PC_STEP         = 21'h000002;
    localparam logic [20:0] PC_RESET        = 21'h000000;
    localparam logic [7:0]  W_RESET         = 8'h00;
    localparam logic [4:0]  STATUS_RESET    = 5'h00;
    localparam logic [3:0]  BANK_RESET      = 4'h0;
    localparam logic [7:0]  LATH_RESET      = 8'h00;
    localparam logic [4:0]  LATU_RESET      = 5'h00;
    localparam logic        IRQ_EN_RESET    = 1'b0;
    typedef enum logic [1:0] {
        ST_EXEC  = 2'b01,
        ST_FLUSH = 2'b10
    } exec_state_t;
endpackage : call_return_pkg

/* File: decode_if.sv */
// Carries the held instruction word to the decoder and its decoded fields back to the execution slice.
// Assumes both ends share the same clock; the decoder is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
    logic [15:0] instr;
    logic        is_call_rel;
    logic        is_soft_reset;
    logic        is_irq_ret;
    logic        is_lit_ret;
    logic        fast_restore;
    logic [10:0] offset;
    logic [7:0]  literal;
    modport dec  (input instr, output is_call_rel, is_soft_reset, is_irq_ret, is_lit_ret, fast_restore, offset, literal);
    modport exec (output instr, input is_call_rel, is_soft_reset, is_irq_ret, is_lit_ret, fast_restore, offset, literal);
endinterface : decode_if
`default_nettype wire

/* File: call_return_decoder.sv */
// Opcode decoder for the relative call, software reset and the two return instructions.
// Assumes the instruction word is stable for the whole instruction cycle.
`timescale 1ns/1ps
`default_nettype none
module call_return_decoder
    import call_return_pkg::*;
(
    decode_if.dec d
);
    function automatic logic match_top(input logic [15:0] word, input logic [15:0] pattern, input int width);
        logic hit;
        hit = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            if (i >= 16 - width && word[i] != pattern[i])
            begin
                hit = 1'b0;
            end
        end
        return hit;
    endfunction : match_top

    always_comb
    begin
        d.is_call_rel   = match_top(d.instr, {CALL_REL_TOP5, 11'h000}, 5);
        d.is_soft_reset = (d.instr == SOFT_RESET_WORD);
        d.is_irq_ret    = match_top(d.instr, {IRQ_RET_TOP15, 1'b0}, 15);
        d.is_lit_ret    = match_top(d.instr, {LIT_RET_TOP8, 8'h00}, 8);
        d.fast_restore  = d.instr[0];
        d.offset        = d.instr[10:0];
        d.literal       = d.instr[7:0];
    end
endmodule : call_return_decoder
`default_nettype wire

/* File: call_return_exec.sv */
// Execution slice for relative call, software reset, return from interrupt and return with literal.
// Assumes instr_i holds the fetched word at phase Q1 of each instruction cycle; other words only advance the PC.
`timescale 1ns/1ps
`default_nettype none
module call_return_exec
    import call_return_pkg::*;
#(
    parameter int DEPTH = call_return_pkg::STACK_DEPTH
)(
    input  wire logic                            mclk_i,
    input  wire logic                            rst_i,
    input  wire logic                            master_clear_i,
    input  wire logic [15:0]                     instr_i,
    input  wire logic                            instr_valid_i,
    input  wire logic                            irq_level_high_i,
    input  wire logic                            shadow_save_i,
    output logic                                 instr_take_o,
    output logic [1:0]                           q_phase_o,
    output logic                                 flush_o,
    output logic                                 soft_reset_o,
    output logic [call_return_pkg::PC_W-1:0]     pc_o,
    output logic [call_return_pkg::PC_W-1:0]     stack_top_o,
    output logic [$clog2(DEPTH+1)-1:0]           stack_level_o,
    output logic                                 stack_overflow_o,
    output logic                                 stack_underflow_o,
    output logic [7:0]                           working_o,
    output logic [call_return_pkg::STATUS_W-1:0] status_o,
    output logic [call_return_pkg::BANK_W-1:0]   bank_select_reg_o,
    output logic [7:0]                           pc_latch_high_o,
    output logic [call_return_pkg::LATU_W-1:0]   pc_latch_upper_o,
    output logic                                 global_irq_enable_high_o,
    output logic                                 peripheral_irq_enable_low_o
);
    localparam int SPW = $clog2(DEPTH+1);

    typedef struct packed {
        exec_state_t                  st;
        logic [1:0]                   q;
        logic [15:0]                  ir;
        logic [PC_W-1:0]              pc;
        logic [7:0]                   w;
        logic [STATUS_W-1:0]          status;
        logic [BANK_W-1:0]            bank_sel;
        logic [7:0]                   working_shadow;
        logic [STATUS_W-1:0]          status_shadow;
        logic [BANK_W-1:0]            bank_select_shadow;
        logic [7:0]                   pc_latch_high;
        logic [LATU_W-1:0]            pc_latch_upper;
        logic                         irq_en_high;
        logic                         irq_en_low;
        logic [DEPTH-1:0][PC_W-1:0]   stk;
        logic [SPW-1:0]               sp;
        logic                         ovf;
        logic                         unf;
        logic                         sw_rst;
    } core_state_t;

    core_state_t s;
    core_state_t next_s;
    decode_if    d ();

    call_return_decoder u_decoder (
        .d (d.dec)
    );

    function automatic core_state_t reset_state();
        core_state_t r;
        r                    = '0;
        r.st                 = ST_EXEC;
        r.q                  = PHASE_Q1;
        r.ir                 = NOP_WORD;
        r.pc                 = PC_RESET;
        r.w                  = W_RESET;
        r.status             = STATUS_RESET;
        r.bank_sel           = BANK_RESET;
        r.working_shadow     = W_RESET;
        r.status_shadow      = STATUS_RESET;
        r.bank_select_shadow = BANK_RESET;
        r.pc_latch_high      = LATH_RESET;
        r.pc_latch_upper     = LATU_RESET;
        r.irq_en_high        = IRQ_EN_RESET;
        r.irq_en_low         = IRQ_EN_RESET;
        return r;
    endfunction : reset_state

    logic            in_exec;
    logic            stack_empty;
    logic            stack_full;
    logic [PC_W-1:0] top_entry;
    logic [PC_W-1:0] return_addr;
    logic [PC_W-1:0] call_target;

    assign d.instr     = s.ir;
    assign in_exec     = (s.st == ST_EXEC);
    assign stack_empty = (s.sp == '0);
    assign stack_full  = (s.sp == SPW'(DEPTH));
    assign top_entry   = stack_empty ? PC_RESET : s.stk[s.sp - SPW'(1)];
    // The program counter still holds this word's address until Q4, so the return address is one step on.
    assign return_addr = s.pc + PC_STEP;
    // The 11-bit field can only hold -1024 to 1023, so every encoding is a legal reach.
    assign call_target = return_addr + {{(PC_W-OFFSET_W-1){d.offset[OFFSET_W-1]}}, d.offset, 1'b0};

    always_comb
    begin
        next_s        = s;
        next_s.q      = s.q + 2'h1;
        next_s.sw_rst = 1'b0;
        if (shadow_save_i)
        begin
            next_s.working_shadow     = s.w;
            next_s.status_shadow      = s.status;
            next_s.bank_select_shadow = s.bank_sel;
        end
        case (s.st)
            ST_EXEC:
            begin
                case (s.q)
                    PHASE_Q1:
                    begin
                        next_s.ir = instr_valid_i ? instr_i : NOP_WORD;
                    end
                    PHASE_Q2:
                    begin
                        if (d.is_call_rel)
                        begin
                            if (stack_full)
                            begin
                                next_s.ovf = 1'b1;
                            end
                            else
                            begin
                                next_s.stk[s.sp] = return_addr;
                                next_s.sp        = s.sp + SPW'(1);
                            end
                        end
                    end
                    PHASE_Q4:
                    begin
                        next_s.pc = return_addr;
                        if (d.is_call_rel)
                        begin
                            next_s.pc = call_target;
                            next_s.st = ST_FLUSH;
                        end
                        else if (d.is_irq_ret || d.is_lit_ret)
                        begin
                            // Only the PC reloads; the high and upper latches keep their values.
                            next_s.pc = top_entry;
                            next_s.st = ST_FLUSH;
                            if (stack_empty)
                            begin
                                next_s.unf = 1'b1;
                            end
                            else
                            begin
                                next_s.sp = s.sp - SPW'(1);
                            end
                            if (d.is_lit_ret)
                            begin
                                next_s.w = d.literal;
                            end
                            else
                            begin
                                if (irq_level_high_i)
                                begin
                                    next_s.irq_en_high = 1'b1;
                                end
                                else
                                begin
                                    next_s.irq_en_low = 1'b1;
                                end
                                // With the bit clear nothing here runs, so the live registers keep their values.
                                if (d.fast_restore)
                                begin
                                    next_s.w        = s.working_shadow;
                                    next_s.status   = s.status_shadow;
                                    next_s.bank_sel = s.bank_select_shadow;
                                end
                            end
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
            ST_FLUSH:
            begin
                // The prefetched word is discarded, so this whole cycle does nothing.
                if (s.q == PHASE_Q4)
                begin
                    next_s.st = ST_EXEC;
                end
            end
            default:
            begin
                next_s.st = ST_EXEC;
            end
        endcase
        // The software reset lands on the state an external master clear gives, except that only it raises sw_rst.
        if (rst_i || master_clear_i || (in_exec && s.q == PHASE_Q2 && d.is_soft_reset))
        begin
            next_s        = reset_state();
            next_s.sw_rst = !rst_i && !master_clear_i;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        s <= next_s;
    end

    assign instr_take_o                = in_exec && (s.q == PHASE_Q1);
    assign q_phase_o                   = s.q;
    assign flush_o                     = (s.st == ST_FLUSH);
    assign soft_reset_o                = s.sw_rst;
    assign pc_o                        = s.pc;
    assign stack_top_o                 = top_entry;
    assign stack_level_o               = s.sp;
    assign stack_overflow_o            = s.ovf;
    assign stack_underflow_o           = s.unf;
    assign working_o                   = s.w;
    assign status_o                    = s.status;
    assign bank_select_reg_o           = s.bank_sel;
    assign pc_latch_high_o             = s.pc_latch_high;
    assign pc_latch_upper_o            = s.pc_latch_upper;
    assign global_irq_enable_high_o    = s.irq_en_high;
    assign peripheral_irq_enable_low_o = s.irq_en_low;
endmodule : call_return_exec
`default_nettype wire

/* File: call_return_exec_sva.sv */
// Concurrent checks for the call, return and software reset execution slice.
// Assumes it is bound to call_return_exec and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module call_return_exec_sva
    import call_return_pkg::*;
#(
    parameter int DEPTH = 31
)(
    input wire logic                       mclk_i,
    input wire logic                       rst_i,
    input wire logic                       master_clear_i,
    input wire logic [15:0]                instr_i,
    input wire logic                       instr_valid_i,
    input wire logic                       irq_level_high_i,
    input wire logic                       instr_take_o,
    input wire logic [1:0]                 q_phase_o,
    input wire logic                       flush_o,
    input wire logic                       soft_reset_o,
    input wire logic [PC_W-1:0]            pc_o,
    input wire logic [PC_W-1:0]            stack_top_o,
    input wire logic [$clog2(DEPTH+1)-1:0] stack_level_o,
    input wire logic                       stack_overflow_o,
    input wire logic [7:0]                 working_o,
    input wire logic [7:0]                 pc_latch_high_o,
    input wire logic [LATU_W-1:0]          pc_latch_upper_o,
    input wire logic                       global_irq_enable_high_o,
    input wire logic                       peripheral_irq_enable_low_o
);
    logic [15:0]                cap_instr;
    logic [PC_W-1:0]            cap_pc;
    logic [PC_W-1:0]            cap_top;
    logic [$clog2(DEPTH+1)-1:0] cap_lvl;
    logic [7:0]                 cap_w;
    // State at the take edge is held so each result can be judged when the flush cycle begins.
    always_ff @(posedge mclk_i)
    begin
        if (instr_take_o)
        begin
            cap_instr <= instr_valid_i ? instr_i : NOP_WORD;
            cap_pc    <= pc_o;
            cap_top   <= stack_top_o;
            cap_lvl   <= stack_level_o;
            cap_w     <= working_o;
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i || master_clear_i);
    take_phase_a: assert property (instr_take_o |-> q_phase_o == PHASE_Q1 && !flush_o)
        else $error("instruction taken outside phase Q1 of an executing cycle");
    phase_walk_a: assert property (q_phase_o == PHASE_Q3 |=> q_phase_o == PHASE_Q4 ##1 q_phase_o == PHASE_Q1)
        else $error("phase sequence broken after Q3");
    flush_len_a: assert property ($rose(flush_o) |-> q_phase_o == PHASE_Q1 ##0 flush_o[*4] ##1 !flush_o)
        else $error("second cycle is not exactly four clocks");
    call_push_a: assert property ($rose(flush_o) && cap_instr[15:11] == CALL_REL_TOP5 && cap_lvl < DEPTH
        |-> stack_top_o == cap_pc + PC_STEP && stack_level_o == cap_lvl + 1'b1) else $error("call push wrong");
    call_target_a: assert property ($rose(flush_o) && cap_instr[15:11] == CALL_REL_TOP5
        |-> pc_o == cap_pc + PC_STEP + {{9{cap_instr[10]}}, cap_instr[10:0], 1'b0}) else $error("call target wrong");
    full_stack_a: assert property ($rose(flush_o) && cap_instr[15:11] == CALL_REL_TOP5 && cap_lvl == DEPTH
        |-> stack_overflow_o && stack_level_o == cap_lvl) else $error("full stack push not refused");
    lit_return_a: assert property ($rose(flush_o) && cap_instr[15:8] == LIT_RET_TOP8 && cap_lvl != 0
        |-> working_o == cap_instr[7:0] && pc_o == cap_top && stack_level_o == cap_lvl - 1'b1)
        else $error("literal return wrong");
    irq_return_a: assert property ($rose(flush_o) && cap_instr[15:1] == IRQ_RET_TOP15 && cap_lvl != 0
        |-> pc_o == cap_top && (irq_level_high_i ? global_irq_enable_high_o : peripheral_irq_enable_low_o))
        else $error("interrupt return wrong");
    irq_keep_a: assert property ($rose(flush_o) && cap_instr[15:0] == {IRQ_RET_TOP15, 1'b0}
        |-> working_o == cap_w) else $error("working register changed without fast restore");
    soft_reset_a: assert property (instr_take_o && instr_valid_i && instr_i == SOFT_RESET_WORD
        |-> ##2 q_phase_o == PHASE_Q1 && pc_o == PC_RESET && stack_level_o == 0 && working_o == W_RESET
            && soft_reset_o)
        else $error("software reset did not clear state");
    soft_pulse_a: assert property (soft_reset_o |=> !soft_reset_o)
        else $error("software reset pulse longer than one clock");
    latch_hold_a: assert property (pc_latch_high_o == LATH_RESET && pc_latch_upper_o == LATU_RESET)
        else $error("pc latches changed");
endmodule : call_return_exec_sva
bind call_return_exec call_return_exec_sva #(.DEPTH(DEPTH)) u_sva (.mclk_i, .rst_i, .master_clear_i, .instr_i,
    .instr_valid_i, .irq_level_high_i, .instr_take_o, .q_phase_o, .flush_o, .soft_reset_o, .pc_o, .stack_top_o,
    .stack_level_o, .stack_overflow_o, .working_o, .pc_latch_high_o, .pc_latch_upper_o, .global_irq_enable_high_o,
    .peripheral_irq_enable_low_o);
`default_nettype wire

/* File: call_return_exec_test.sv */
// Self-checking bench for call_return_exec: calls, returns, shadow restore and both resets.
// Assumes the checker is bound separately; a stack model in the bench predicts every result.
`timescale 1ns/1ps
`default_nettype none
module call_return_exec_test;
    import call_return_pkg::*;
    localparam int DEPTH = 31;
    logic mclk_i = 1'b0, rst_i = 1'b1, master_clear_i = 1'b0, instr_valid_i = 1'b0;
    logic irq_level_high_i = 1'b0, shadow_save_i = 1'b0;
    logic instr_take_o, flush_o, soft_reset_o, stack_overflow_o, stack_underflow_o;
    logic global_irq_enable_high_o, peripheral_irq_enable_low_o;
    logic [15:0]     instr_i = 16'h0000, lfsr = 16'h42d8;
    logic [1:0]      q_phase_o;
    logic [PC_W-1:0] pc_o, stack_top_o, pc_m, st[$];
    logic [4:0]      stack_level_o, status_o, pc_latch_upper_o;
    logic [3:0]      bank_select_reg_o;
    logic [7:0]      working_o, pc_latch_high_o, shadow_w_m;
    int              fail_count = 0, total_checks = 0, cyc = 0;
    always #4 mclk_i = ~mclk_i;
    call_return_exec #(.DEPTH(DEPTH)) u_dut (.mclk_i, .rst_i, .master_clear_i, .instr_i, .instr_valid_i,
        .irq_level_high_i, .shadow_save_i, .instr_take_o, .q_phase_o, .flush_o, .soft_reset_o, .pc_o, .stack_top_o,
        .stack_level_o, .stack_overflow_o, .stack_underflow_o, .working_o, .status_o, .bank_select_reg_o,
        .pc_latch_high_o, .pc_latch_upper_o, .global_irq_enable_high_o, .peripheral_irq_enable_low_o);
    function automatic logic [15:0] step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : step
    function automatic logic [PC_W-1:0] target(input logic [PC_W-1:0] pc, input logic [10:0] n);
        return pc + PC_STEP + {{9{n[10]}}, n, 1'b0};
    endfunction : target
    task automatic final_report();
        if (fail_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [PC_W-1:0] exp, input logic [PC_W-1:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_flag(input string what, input logic exp, input logic got);
        chk(what, PC_W'(exp), PC_W'(got));
    endtask : chk_flag
    // Results are read four clocks after the take edge, once the Q4 writes have landed.
    task automatic issue(input logic [15:0] w);
        for (int n = 0; n < 20 && instr_take_o !== 1'b1; n++)
        begin
            @(posedge mclk_i);
            #1;
        end
        instr_i = w;
        instr_valid_i = 1'b1;
        @(posedge mclk_i);
        #1 instr_valid_i = 1'b0;
        instr_i = lfsr;
        repeat (4) @(posedge mclk_i);
        #1;
    endtask : issue
    task automatic do_call(input logic [10:0] n);
        logic [PC_W-1:0] t;
        t = target(pc_m, n);
        if (st.size() < DEPTH)
            st.push_back(pc_m + PC_STEP);
        issue({CALL_REL_TOP5, n});
        pc_m = t;
        chk("pc", t, pc_o);
        chk("top", st[$], stack_top_o);
        chk("level", PC_W'(st.size()), PC_W'(stack_level_o));
    endtask : do_call
    task automatic do_ret(input logic [15:0] w);
        logic [PC_W-1:0] e;
        e = (st.size() != 0) ? st.pop_back() : PC_RESET;
        issue(w);
        pc_m = e;
        chk("pc", e, pc_o);
        chk("level", PC_W'(st.size()), PC_W'(stack_level_o));
        chk("latches", '0, PC_W'({pc_latch_upper_o, pc_latch_high_o}));
    endtask : do_ret
    task automatic zero_check();
        chk("pc", PC_RESET, pc_o);
        chk("level", '0, PC_W'(stack_level_o));
        chk("regs", '0, PC_W'({working_o, status_o, bank_select_reg_o}));
        chk_flag("irq_enable", IRQ_EN_RESET, global_irq_enable_high_o | peripheral_irq_enable_low_o);
        st.delete();
    endtask : zero_check
    initial
    begin
        repeat (10) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        pc_m = PC_RESET;
        do_ret({LIT_RET_TOP8, 8'h5a});
        chk_flag("underflow", 1'b1, stack_underflow_o);
        do_call(11'h400);
        do_call(11'h3ff);
        for (int i = 0; i < DEPTH; i++)
        begin
            lfsr = step(lfsr);
            do_call(lfsr[10:0]);
        end
        chk_flag("overflow", 1'b1, stack_overflow_o);
        for (int i = 0; i < 8; i++)
        begin
            lfsr = step(lfsr);
            do_ret({LIT_RET_TOP8, lfsr[7:0]});
            chk("w", PC_W'(lfsr[7:0]), PC_W'(working_o));
        end
        shadow_w_m = lfsr[7:0];
        shadow_save_i = 1'b1;
        @(posedge mclk_i);
        #1 shadow_save_i = 1'b0;
        for (int s = 0; s < 2; s++)
        begin
            lfsr = step(lfsr);
            do_ret({LIT_RET_TOP8, lfsr[7:0]});
            irq_level_high_i = s[0];
            do_ret({IRQ_RET_TOP15, s[0]});
            chk("w", PC_W'(s != 0 ? shadow_w_m : lfsr[7:0]), PC_W'(working_o));
            chk_flag("irq_enable", 1'b1, s != 0 ? global_irq_enable_high_o : peripheral_irq_enable_low_o);
        end
        do_call(11'h010);
        issue(SOFT_RESET_WORD);
        zero_check();
        // The freed Q1 after the reset executes as a no-op, so the next word sits one step on.
        pc_m = PC_STEP;
        do_call(11'h7f0);
        master_clear_i = 1'b1;
        @(posedge mclk_i);
        #1 master_clear_i = 1'b0;
        zero_check();
        pc_m = PC_RESET;
        do_ret({LIT_RET_TOP8, 8'hff});
        chk("w", PC_W'(8'hff), PC_W'(working_o));
        final_report();
    end
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            fail_count++;
            final_report();
        end
    end
endmodule : call_return_exec_test
`default_nettype wire
